// [hdl/mwd_defines.svh]
// Constants for the margining and watchdog two-wire slave
`ifndef MWD_DEFINES_SVH
`define MWD_DEFINES_SVH

`define MWD_CLK_NS      8
`define MWD_MS_NS       1000000
`define MWD_MS_CYCLES   (`MWD_MS_NS / `MWD_CLK_NS)
`define MWD_ADDR_HIGH   5'h0c
`define MWD_OP_MARGIN   3'h1
`define MWD_OP_UNUSED   3'h2
`define MWD_OP_WDOG     3'h3
`define MWD_VAL_NULL    5'h00
`define MWD_MARGIN_NOM  4'h0
`define MWD_MARGIN_BAD  4'h8
`define MWD_BIT_LAST    4'h8
`define MWD_WD_MS_1280  11'h500
`define MWD_WD_MS_320   11'h140
`define MWD_WD_MS_80    11'h050
`define MWD_WD_MS_20    11'h014
`define MWD_WD_SEL_RST  2'h0

`endif

// [hdl/mwd_pkg.sv]
// Types for the margining and watchdog two-wire slave
package mwd_pkg;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR,
    PH_ACK_ADDR,
    PH_DATA,
    PH_ACK_DATA,
    PH_SKIP
  } mwd_phase_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic sel_m;
    logic sel_s;
    logic id_m;
    logic id_s;
  } mwd_front_t;

  typedef struct packed {
    mwd_phase_t  phase;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic        sda_oe_n;
    logic        sda_o;
    logic        armed;
    logic [2:0]  armed_op;
    logic [3:0]  linear_regulator;
    logic [3:0]  sw;
    logic        wd_en;
    logic [1:0]  wd_sel;
    logic        wd_win;
    logic [16:0] ms_div;
    logic [10:0] wd_ms;
    logic        wd_expired;
    logic        win_open;
    logic        osc_out;
    logic [1:0]  id_bits;
  } mwd_core_t;

endpackage

// [hdl/mwd_bit_if.sv]
// Bus events passed from the pin front end to the slave core
`timescale 1ns/1ps
interface mwd_bit_if;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic start;
  logic stop;
  logic strap_sel;
  logic strap_id;

  modport front (output scl_rise, output scl_fall, output sda, output start,
                 output stop, output strap_sel, output strap_id);
  modport core  (input scl_rise, input scl_fall, input sda, input start,
                 input stop, input strap_sel, input strap_id);
endinterface

// [hdl/mwd_bus_front.sv]
// Pin synchronisers and start, stop and clock edge detection
`timescale 1ns/1ps
module mwd_bus_front (
  input  wire logic mclk_in,
  input  wire logic sys_rst_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic oscillator_sync_select_pin_in,
  input  wire logic slave_id_strap_in,
  mwd_bit_if.front  bus
);

  mwd_pkg::mwd_front_t f_q;
  mwd_pkg::mwd_front_t f_d;

  always_comb begin
    f_d       = f_q;
    f_d.scl_m = scl_in;
    f_d.scl_s = f_q.scl_m;
    f_d.scl_p = f_q.scl_s;
    f_d.sda_m = sda_in;
    f_d.sda_s = f_q.sda_m;
    f_d.sda_p = f_q.sda_s;
    f_d.sel_m = oscillator_sync_select_pin_in;
    f_d.sel_s = f_q.sel_m;
    f_d.id_m  = slave_id_strap_in;
    f_d.id_s  = f_q.id_m;
  end

  // Idle bus is high on both lines
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      f_q <= '1;
    end else begin
      f_q <= f_d;
    end
  end

  // Start and stop are data edges while the clock stays high
  assign bus.scl_rise  = f_q.scl_s & ~f_q.scl_p;
  assign bus.scl_fall  = ~f_q.scl_s & f_q.scl_p;
  assign bus.sda       = f_q.sda_s;
  assign bus.start     = f_q.scl_s & f_q.scl_p & f_q.sda_p & ~f_q.sda_s;
  assign bus.stop      = f_q.scl_s & f_q.scl_p & ~f_q.sda_p & f_q.sda_s;
  assign bus.strap_sel = f_q.sel_s;
  assign bus.strap_id  = f_q.id_s;

endmodule

// [hdl/mwd_slave.sv]
// Two-wire slave for voltage margining and watchdog programming
`timescale 1ns/1ps
`include "mwd_defines.svh"

module mwd_slave #(
  parameter int MS_CYCLES = `MWD_MS_CYCLES
) (
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  input  wire logic       oscillator_sync_select_pin_in,
  input  wire logic       slave_id_strap_in,
  output logic            oscillator_sync_pin_is_output_out,
  output logic [3:0]      linear_regulator_margin_out,
  output logic [3:0]      switcher_margin_out,
  output logic            watchdog_enable_out,
  output logic [1:0]      watchdog_period_sel_out,
  output logic            windowed_timeout_out,
  output logic            watchdog_window_open_out,
  output logic            watchdog_expired_out
);

  mwd_bit_if bus ();

  mwd_bus_front u_front (
    .mclk_in                       (mclk_in),
    .sys_rst_in                    (sys_rst_in),
    .scl_in                        (scl_in),
    .sda_in                        (sda_in),
    .oscillator_sync_select_pin_in (oscillator_sync_select_pin_in),
    .slave_id_strap_in             (slave_id_strap_in),
    .bus                           (bus.front)
  );

  mwd_pkg::mwd_core_t s_q;
  mwd_pkg::mwd_core_t s_d;

  // Timeout length in milliseconds per period select
  function automatic logic [10:0] period_ms(input logic [1:0] sel);
    logic [10:0] ms;
    unique case (sel)
      2'h0: ms = `MWD_WD_MS_1280;
      2'h1: ms = `MWD_WD_MS_320;
      2'h2: ms = `MWD_WD_MS_80;
      2'h3: ms = `MWD_WD_MS_20;
    endcase
    return ms;
  endfunction

  logic [6:0]  own_addr;
  logic [7:0]  rx_byte;
  logic [2:0]  rx_op;
  logic [4:0]  rx_val;
  logic        ms_tick;
  logic [10:0] limit_ms;

  assign own_addr = {`MWD_ADDR_HIGH, s_q.id_bits};
  assign rx_byte  = s_q.shreg;
  assign rx_op    = rx_byte[7:5];
  assign rx_val   = rx_byte[4:0];
  assign ms_tick  = (s_q.ms_div == 17'(MS_CYCLES - 1));
  assign limit_ms = period_ms(s_q.wd_sel);

  always_comb begin
    s_d            = s_q;
    s_d.wd_expired = 1'b0;
    s_d.id_bits    = {bus.strap_sel, bus.strap_id};
    s_d.osc_out    = bus.strap_sel;

    // Millisecond base and watchdog counter
    s_d.ms_div = ms_tick ? 17'h0_0000 : s_q.ms_div + 17'h0_0001;
    if (s_q.wd_en && ms_tick) begin
      if (s_q.wd_ms == limit_ms - 11'h001) begin
        s_d.wd_ms      = 11'h000;
        s_d.wd_expired = 1'b1;
      end else begin
        s_d.wd_ms = s_q.wd_ms + 11'h001;
      end
    end
    s_d.win_open = !s_q.wd_win || (s_q.wd_ms >= (limit_ms >> 1));

    // Bit engine: sample on clock rise, drive on clock fall
    unique case (s_q.phase)
      mwd_pkg::PH_IDLE, mwd_pkg::PH_SKIP: begin
        s_d.sda_oe_n = 1'b1;
      end
      mwd_pkg::PH_ADDR: begin
        if (bus.scl_rise) begin
          s_d.shreg   = {s_q.shreg[6:0], bus.sda};
          s_d.bit_cnt = s_q.bit_cnt + 4'h1;
        end else if (bus.scl_fall && s_q.bit_cnt == `MWD_BIT_LAST) begin
          s_d.bit_cnt = 4'h0;
          // Read requests are not supported and get no acknowledge
          if (rx_byte[7:1] == own_addr && !rx_byte[0]) begin
            s_d.phase    = mwd_pkg::PH_ACK_ADDR;
            s_d.sda_oe_n = 1'b0;
          end else begin
            s_d.phase = mwd_pkg::PH_SKIP;
          end
        end
      end
      mwd_pkg::PH_ACK_ADDR, mwd_pkg::PH_ACK_DATA: begin
        if (bus.scl_fall) begin
          s_d.sda_oe_n = 1'b1;
          s_d.phase    = mwd_pkg::PH_DATA;
        end
      end
      mwd_pkg::PH_DATA: begin
        if (bus.scl_rise) begin
          s_d.shreg   = {s_q.shreg[6:0], bus.sda};
          s_d.bit_cnt = s_q.bit_cnt + 4'h1;
        end else if (bus.scl_fall && s_q.bit_cnt == `MWD_BIT_LAST) begin
          s_d.bit_cnt  = 4'h0;
          s_d.phase    = mwd_pkg::PH_ACK_DATA;
          s_d.sda_oe_n = 1'b0;
          // Command decode
          if (s_q.armed && rx_op == s_q.armed_op) begin
            if (rx_op == `MWD_OP_MARGIN) begin
              if (rx_val[3:0] != `MWD_MARGIN_BAD) begin
                if (rx_val[4]) begin
                  s_d.sw = rx_val[3:0];
                end else begin
                  s_d.linear_regulator = rx_val[3:0];
                end
              end
            end else if (rx_val == `MWD_VAL_NULL) begin
              s_d.wd_en = 1'b0;
              s_d.wd_ms = 11'h000;
            end else if (rx_val[4:3] == 2'h1) begin
              s_d.wd_sel = rx_val[1:0];
              s_d.wd_win = rx_val[2];
              if (!s_q.wd_en) begin
                s_d.wd_en  = 1'b1;
                s_d.wd_ms  = 11'h000;
                s_d.ms_div = 17'h0_0000;
              end else if (s_q.win_open) begin
                s_d.wd_ms  = 11'h000;
                s_d.ms_div = 17'h0_0000;
              end
            end
          end else if (rx_val == `MWD_VAL_NULL &&
                       (rx_op == `MWD_OP_MARGIN || rx_op == `MWD_OP_WDOG)) begin
            s_d.armed    = 1'b1;
            s_d.armed_op = rx_op;
          end
        end
      end
      default: begin
        s_d.phase = mwd_pkg::PH_IDLE;
      end
    endcase

    // Stop wins over start; both drop the armed first command
    if (bus.start) begin
      s_d.phase    = mwd_pkg::PH_ADDR;
      s_d.bit_cnt  = 4'h0;
      s_d.sda_oe_n = 1'b1;
      s_d.armed    = 1'b0;
    end
    if (bus.stop) begin
      s_d.phase    = mwd_pkg::PH_IDLE;
      s_d.bit_cnt  = 4'h0;
      s_d.sda_oe_n = 1'b1;
      s_d.armed    = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      s_q            <= '0;
      s_q.phase      <= mwd_pkg::PH_IDLE;
      s_q.sda_oe_n   <= 1'b1;
      s_q.linear_regulator        <= `MWD_MARGIN_NOM;
      s_q.sw         <= `MWD_MARGIN_NOM;
      s_q.wd_sel     <= `MWD_WD_SEL_RST;
      s_q.id_bits    <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end

  assign sda_out                           = s_q.sda_o;
  assign sda_oe_n_out                      = s_q.sda_oe_n;
  assign oscillator_sync_pin_is_output_out = s_q.osc_out;
  assign linear_regulator_margin_out       = s_q.linear_regulator;
  assign switcher_margin_out               = s_q.sw;
  assign watchdog_enable_out               = s_q.wd_en;
  assign watchdog_period_sel_out           = s_q.wd_sel;
  assign windowed_timeout_out              = s_q.wd_win;
  assign watchdog_window_open_out          = s_q.win_open;
  assign watchdog_expired_out              = s_q.wd_expired;

endmodule

// [bench/mwd_slave_props.sv]
// Port assertions for the margining and watchdog slave
`timescale 1ns/1ps
module mwd_slave_props (
  input wire logic       mclk_in,
  input wire logic       sys_rst_in,
  input wire logic       scl_in,
  input wire logic       oscillator_sync_select_pin_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n_out,
  input wire logic       oscillator_sync_pin_is_output_out,
  input wire logic [3:0] linear_regulator_margin_out,
  input wire logic [3:0] switcher_margin_out,
  input wire logic       watchdog_enable_out,
  input wire logic       windowed_timeout_out,
  input wire logic       watchdog_window_open_out,
  input wire logic       watchdog_expired_out
);
  logic [2:0] up_q;
  logic [2:0] up_d;
  assign up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
  always_ff @(posedge mclk_in) begin
    up_q <= sys_rst_in ? 3'h0 : up_d;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  pull_low_a: assert property (!sda_oe_n_out |-> !sda_out)
    else $error("data line driven high");
  osc_follow_a: assert property (up_q >= 3'h4 |->
    oscillator_sync_pin_is_output_out == $past(oscillator_sync_select_pin_in, 3))
    else $error("sync pin mode not from strap");
  ack_hold_a: assert property ($fell(sda_oe_n_out) |=> !sda_oe_n_out [*6])
    else $error("acknowledge too short");
  ack_scl_low_a: assert property ($changed(sda_oe_n_out) |-> !scl_in)
    else $error("data changed with clock high");
  margin_at_ack_a: assert property ($changed({linear_regulator_margin_out, switcher_margin_out})
    |-> $fell(sda_oe_n_out))
    else $error("margin changed outside a byte end");
  wd_at_ack_a: assert property ($changed({watchdog_enable_out, windowed_timeout_out})
    |-> $fell(sda_oe_n_out))
    else $error("watchdog mode changed outside a byte end");
  no_bad_margin_a: assert property (linear_regulator_margin_out != 4'h8
    && switcher_margin_out != 4'h8)
    else $error("unlisted margin code taken");
  open_unwin_a: assert property ((watchdog_enable_out && !windowed_timeout_out) [*2]
    |-> watchdog_window_open_out)
    else $error("window closed in unwindowed mode");
  expire_pulse_a: assert property (watchdog_expired_out
    |-> watchdog_enable_out ##1 !watchdog_expired_out)
    else $error("bad expiry pulse");
endmodule

// [bench/mwd_master_model.sv]
// Behavioural two-wire bus master for the slave pins
`timescale 1ns/1ps
module mwd_master_model (
  input  wire logic mclk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_drv_out
);
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // Data falls while clock high
  task automatic start();
    tick(1);
    sda_drv_out = 1'b1;
    tick(4);
    scl_out = 1'b1;
    tick(4);
    sda_drv_out = 1'b0;
    tick(4);
    scl_out = 1'b0;
  endtask
  // Only the master ends a transfer
  task automatic stop();
    tick(1);
    sda_drv_out = 1'b0;
    tick(4);
    scl_out = 1'b1;
    tick(4);
    sda_drv_out = 1'b1;
    tick(4);
  endtask
  // Low 5, high 3 cycles, MSB first
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 8; i >= 0; i--) begin
      tick(1);
      sda_drv_out = (i == 0) ? 1'b1 : b[i-1];
      tick(4);
      scl_out = 1'b1;
      tick(2);
      s = sda_in;
      tick(1);
      scl_out = 1'b0;
    end
    ack = !s;
  endtask
endmodule

// [bench/mwd_slave_tb_top.sv]
// Top testbench for the margining and watchdog slave
`timescale 1ns/1ps
`include "mwd_defines.svh"
module mwd_slave_tb_top;
  localparam int MS = 16;
  localparam int P20 = `MWD_WD_MS_20 * MS;
  localparam int P80 = `MWD_WD_MS_80 * MS;
  logic       mclk_in = 1'b0;
  logic       sys_rst_in = 1'b1;
  logic       sel = 1'b1;
  logic       sid = 1'b0;
  logic       scl_in;
  logic       sda_drv;
  logic       sda_out;
  logic       sda_oe_n_out;
  logic       osc;
  logic       wd_en;
  logic       win;
  logic       win_open;
  logic       expd;
  logic [3:0] linear_regulator;
  logic [3:0] sw;
  logic [1:0] per;
  logic [7:0] ad;
  logic [3:0] e = 4'h0;
  int         n;
  int         bad_count = 0;
  int         cmp_count = 0;
  wire        sda_w = sda_drv & (sda_oe_n_out | sda_out);

  initial forever #4 mclk_in = ~mclk_in;
  mwd_master_model mst_u (.mclk_in, .sda_in(sda_w), .scl_out(scl_in), .sda_drv_out(sda_drv));
  mwd_slave #(.MS_CYCLES(MS)) dut_u (.mclk_in, .sys_rst_in, .scl_in, .sda_in(sda_w), .sda_out,
    .sda_oe_n_out, .oscillator_sync_select_pin_in(sel), .slave_id_strap_in(sid),
    .oscillator_sync_pin_is_output_out(osc), .linear_regulator_margin_out(linear_regulator),
    .switcher_margin_out(sw), .watchdog_enable_out(wd_en), .watchdog_period_sel_out(per),
    .windowed_timeout_out(win), .watchdog_window_open_out(win_open), .watchdog_expired_out(expd));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic xfer(input logic [7:0] q[3], input int k, input logic ea);
    logic a;
    mst_u.start();
    for (int i = 0; i < k; i++) begin
      mst_u.send_byte(q[i], a);
      chk({15'h0, a}, {15'h0, ea});
    end
    mst_u.stop();
  endtask
  task automatic wait_exp();
    n = 0;
    do begin
      mst_u.tick(1);
      n++;
    end while (expd !== 1'b1 && n < 4000);
  endtask

  initial begin
    #400000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge mclk_in);
    #1 sys_rst_in = 1'b0;
    chk({linear_regulator, sw, wd_en, sda_oe_n_out, expd}, 16'h0002);
    for (int k = 0; k < 4; k++) begin
      {sel, sid} = k[1:0];
      mst_u.tick(6);
      ad = {`MWD_ADDR_HIGH, k[1:0], 1'b0};
      xfer('{ad, 8'h00, 8'h00}, 1, 1'b1);
      xfer('{ad ^ 8'h02, 8'h00, 8'h00}, 1, 1'b0);
      xfer('{ad | 8'h01, 8'h00, 8'h00}, 1, 1'b0);
      chk({15'h0, osc}, {15'h0, sel});
    end
    xfer('{ad, 8'h25, 8'h00}, 2, 1'b1);
    chk({8'h0, linear_regulator, sw}, 16'h0000);
    for (int v = 0; v < 16; v++) begin
      xfer('{ad, 8'h20, {4'h2, v[3:0]}}, 3, 1'b1);
      if (v != 8) e = v[3:0];
      chk({12'h0, linear_regulator}, {12'h0, e});
    end
    xfer('{ad, 8'h20, 8'h32}, 3, 1'b1);
    chk({8'h0, linear_regulator, sw}, 16'h00f2);
    xfer('{ad, 8'h40, 8'h3e}, 3, 1'b1);
    xfer('{ad, 8'h3e, 8'h00}, 2, 1'b1);
    chk({8'h0, linear_regulator, sw}, 16'h00f2);
    for (int p = 0; p < 8; p++) begin
      xfer('{ad, 8'h60, {5'h0d, p[2:0]}}, 3, 1'b1);
      chk({12'h0, wd_en, win, per}, {12'h0, 1'b1, p[2:0]});
    end
    xfer('{ad, 8'h60, 8'h00}, 2, 1'b1);
    chk({15'h0, wd_en}, 16'h0001);
    xfer('{ad, 8'h60, 8'h60}, 3, 1'b1);
    chk({15'h0, wd_en}, 16'h0000);
    xfer('{ad, 8'h60, 8'h6b}, 3, 1'b1);
    chk({12'h0, wd_en, win, per}, 16'h000b);
    chk({15'h0, win_open}, 16'h0001);
    wait_exp();
    chk({15'h0, n > P20 - 100 && n <= P20}, 16'h0001);
    wait_exp();
    chk(n[15:0], P20[15:0]);
    xfer('{ad, 8'h60, 8'h6b}, 3, 1'b1);
    wait_exp();
    chk({15'h0, n > P20 - 40 && n <= P20}, 16'h0001);
    // Windowed 80 ms: early refresh must not clear the timer
    xfer('{ad, 8'h60, 8'h6e}, 3, 1'b1);
    chk({13'h0, win, per}, 16'h0006);
    chk({15'h0, win_open}, 16'h0000);
    xfer('{ad, 8'h60, 8'h6e}, 3, 1'b1);
    wait_exp();
    chk({15'h0, n > P80 - 320 && n < P80 - 160}, 16'h0001);
    tally_and_finish();
  end
endmodule

bind mwd_slave mwd_slave_props props_u (.mclk_in, .sys_rst_in, .scl_in, .oscillator_sync_select_pin_in,
  .sda_out, .sda_oe_n_out, .oscillator_sync_pin_is_output_out, .linear_regulator_margin_out,
  .switcher_margin_out, .watchdog_enable_out, .windowed_timeout_out, .watchdog_window_open_out,
  .watchdog_expired_out);
